// file: shared/pin_mux_consts.svh
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH
`define PB_SEL_ADDR 12'h000
`define AN_SEL_ADDR 12'h004
`define PB_SEL_MASK 32'h0000_3fff
`define PB_SEL_RESET 32'h0000_0000
`define AN_SEL_MASK 32'h3330_3330
`define AN_SEL_RESET 32'h2220_2220
`define AN_PIN_LSB0 4
`define AN_PIN_LSB1 8
`define AN_PIN_LSB2 12
`define AN_PIN_LSB3 20
`define AN_PIN_LSB4 24
`define AN_PIN_LSB5 28
`endif

// file: shared/pin_mux_pkg.sv
package pin_mux_pkg;
  typedef enum logic [1:0] {SEL_GPIO, SEL_ALT1, SEL_ALT2, SEL_ALT3} sel_code_t;
  typedef struct packed {
    logic [6:0] out;
    logic [6:0] oe;
  } pad_drive_t;
  typedef struct packed {
    logic paddr_ok;
    logic [31:0] data;
  } rd_word_t;
endpackage

// file: tb/pad_model.sv
`timescale 1ns/1ps
module pad_model
(
  // design side
  input wire logic [6:0] pad_out,
  input wire logic [6:0] pad_oe,
  // outside drive, seen only where the pad is released
  input wire logic [6:0] ext_level,
  output logic [6:0] pad_in
);
  // a released pad shows the outside level, never the last driven value
  always_comb
  begin
    for (int i = 0; i < 7; i++)
    begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_level[i];
    end
  end
endmodule

// file: tb/port_b_pin_function_select_tb.sv
`timescale 1ns/1ps
`include "pin_mux_consts.svh"
module port_b_pin_function_select_tb;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err, jtag_reset, jtag_tdo;
  logic jtag_tck, jtag_tms, jtag_tdi, external_oscillator_clock_in, comparator2_output;
  logic i2c_port_clock_line_oe, i2c_port_data_line_oe, i2c_port_clock_line;
  logic i2c_port_data_line, pwm_sync_pulse_out, pwm_sync_pulse_in;
  logic conversion_start_b_out, conversion_start_a_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] gpio_out, gpio_oe, gpio_in, pad_in, pad_out, pad_oe, ext_level;
  logic [5:0] analog_digital_en;
  logic [6:0] eo [4] = '{7'h55, 7'h50, 7'h56, 7'h56};
  logic [6:0] ee [4] = '{7'h7c, 7'h7f, 7'h7e, 7'h7f};
  logic [2:0] es [4] = '{3'b110, 3'b000, 3'b111, 3'b110};
  logic [6:0] eg [4] = '{7'h57, 7'h50, 7'h57, 7'h56};
  int bad_count, checks_done;

  port_b_pin_function_select u_dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .jtag_reset, .jtag_tdo, .jtag_tck, .jtag_tms,
    .jtag_tdi, .external_oscillator_clock_in, .comparator2_output, .i2c_port_clock_line_oe,
    .i2c_port_data_line_oe, .i2c_port_clock_line, .i2c_port_data_line, .pwm_sync_pulse_out,
    .pwm_sync_pulse_in, .conversion_start_b_out, .conversion_start_a_out, .gpio_out,
    .gpio_oe, .gpio_in, .pad_in, .pad_out, .pad_oe, .analog_digital_en);
  pad_model u_pads (.pad_out, .pad_oe, .ext_level, .pad_in);

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask

  // holds the request until pready is seen high, then takes data and response
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a wait that never gets its answer
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic conclude();
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #20000;
    bad_count++;
    conclude();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, jtag_reset, comparator2_output} = '0;
    {i2c_port_clock_line_oe, i2c_port_data_line_oe, jtag_tdo} = 3'b111;
    {pwm_sync_pulse_out, conversion_start_b_out, conversion_start_a_out} = 3'b110;
    gpio_out = 7'h55;
    gpio_oe = 7'h7c;
    ext_level = 7'h7f;
    sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b0, `PB_SEL_ADDR, 32'h0);
      check("pb reset", 32'h0, rd);
      apb(1'b0, `AN_SEL_ADDR, 32'h0);
      check("an reset", 32'h2220_2220, rd);
      check("an en", 32'h0, {26'h0, analog_digital_en});
      apb(1'b1, `PB_SEL_ADDR, 32'hffff_ffff);
      apb(1'b0, `PB_SEL_ADDR, 32'h0);
      check("pb mask", 32'h3fff, rd);
      apb(1'b1, 12'h008, 32'h0);
      check("bad wr err", 32'h1, {31'h0, err});
      apb(1'b0, 12'h008, 32'h0);
      check("bad rd", 32'h0, rd);
      check("bad rd err", 32'h1, {31'h0, err});
      apb(1'b0, `PB_SEL_ADDR, 32'h0);
      check("pb kept", 32'h3fff, rd);
      check("good err", 32'h0, {31'h0, err});
      // mid-run reset must bring back every reset value
      @(posedge clk);
      sys_rst <= ~k[0];
      @(posedge clk);
      sys_rst <= 1'b0;
    end
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, `PB_SEL_ADDR, {18'h0, {7{c[1:0]}}});
      @(negedge clk);
      check("pad_out", {25'h0, eo[c]}, {25'h0, pad_out});
      check("pad_oe", {25'h0, ee[c]}, {25'h0, pad_oe});
      check("side in", {29'h0, es[c]},
        {29'h0, i2c_port_clock_line, i2c_port_data_line, pwm_sync_pulse_in});
      check("gpio_in", {25'h0, eg[c]}, {25'h0, gpio_in});
    end
    apb(1'b1, `PB_SEL_ADDR, 32'h0);
    for (int j = 0; j < 3; j++)
    begin
      @(posedge clk);
      jtag_reset <= (j < 2);
      ext_level <= {7{j[0]}};
      @(negedge clk);
      check("jtag in", (j == 2) ? 32'h2 : {29'h0, {3{j[0]}}},
        {29'h0, jtag_tck, jtag_tms, jtag_tdi});
      check("tdo pad", {31'h0, j < 2}, {31'h0, pad_out[5]});
      check("osc", {31'h0, j != 0}, {31'h0, external_oscillator_clock_in});
    end
    apb(1'b1, `AN_SEL_ADDR, 32'h2120_1210);
    apb(1'b0, `AN_SEL_ADDR, 32'h0);
    check("an rd", 32'h2120_1210, rd);
    check("an en", 32'h15, {26'h0, analog_digital_en});
    conclude();
  end
endmodule

// file: verilog/port_b_pin_function_select.sv
// Notes on behaviour
// - pin 38 selector bits 13:12, 00 gives general I/O, reset 00.
// - jtag reset input high puts test clock on pin 38.
// - pin 38 also feeds external oscillator clock to core clocking.
// - pin 37 selector bits 11:10, 00 general I/O, jtag data out when jtag reset.
// - pin 36 selector bits 9:8, 00 general I/O, jtag mode select when jtag reset.
// - pin 35 selector bits 7:6, 00 general I/O, jtag data in when jtag reset.
// - pin 34 bits 5:4, 00 general I/O, 01 comparator 2 output.
// - pin 33 bits 3:2: general I/O, i2c clock, sync out, conversion start b.
// - pin 32 bits 1:0: general I/O, i2c data, sync in, conversion start a.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "pin_mux_consts.svh"
module port_b_pin_function_select
  import pin_mux_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // jtag
  input wire logic jtag_reset,
  input wire logic jtag_tdo,
  output logic jtag_tck,
  output logic jtag_tms,
  output logic jtag_tdi,
  // clocking
  output logic external_oscillator_clock_in,
  // peripherals
  input wire logic comparator2_output,
  input wire logic i2c_port_clock_line_oe,
  input wire logic i2c_port_data_line_oe,
  output logic i2c_port_clock_line,
  output logic i2c_port_data_line,
  input wire logic pwm_sync_pulse_out,
  output logic pwm_sync_pulse_in,
  input wire logic conversion_start_b_out,
  input wire logic conversion_start_a_out,
  // general purpose logic, bit 0 is pin 32
  input wire logic [6:0] gpio_out,
  input wire logic [6:0] gpio_oe,
  output logic [6:0] gpio_in,
  // pads, bit 0 is pin 32
  input wire logic [6:0] pad_in,
  output logic [6:0] pad_out,
  output logic [6:0] pad_oe,
  // analog pin digital enables, pins 2,4,6,10,12,14
  output logic [5:0] analog_digital_en
);

  logic [31:0] pb_reg, pb_next;
  logic [31:0] an_reg, an_next;
  logic [31:0] rdata_reg, rdata_next;
  rd_word_t rd;
  pad_drive_t drv;
  sel_code_t sel32, sel33, sel34;
  logic wr_acc, rd_acc;
  localparam int an_lsb [6] = '{`AN_PIN_LSB0, `AN_PIN_LSB1, `AN_PIN_LSB2,
    `AN_PIN_LSB3, `AN_PIN_LSB4, `AN_PIN_LSB5};

  // single wait-free access: setup then access answers at once
  assign pready = 1'b1;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;

  always_comb
  begin
    rd.paddr_ok = 1'b1;
    rd.data = 32'h0000_0000;
    unique case (paddr)
      `PB_SEL_ADDR: rd.data = pb_reg;
      `AN_SEL_ADDR: rd.data = an_reg;
      default: rd.paddr_ok = 1'b0;
    endcase
  end

  // unmapped addresses answer with an error, reading zero
  assign pslverr = psel & penable & ~rd.paddr_ok;

  always_comb
  begin
    pb_next = pb_reg;
    an_next = an_reg;
    rdata_next = rdata_reg;
    if (wr_acc && paddr == `PB_SEL_ADDR)
    begin
      pb_next = pwdata & `PB_SEL_MASK;
    end
    if (wr_acc && paddr == `AN_SEL_ADDR)
    begin
      // nonzero reserved writes are dropped rather than trusted
      an_next = pwdata & `AN_SEL_MASK;
    end
    if (rd_acc)
    begin
      rdata_next = rd.data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pb_reg <= `PB_SEL_RESET;
      an_reg <= `AN_SEL_RESET;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pb_reg <= pb_next;
      an_reg <= an_next;
      rdata_reg <= rdata_next;
    end
  end

  assign prdata = rdata_reg;

  // analog digital path enabled only while upper selector bit is clear
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_an
      assign analog_digital_en[g] = ~an_reg[an_lsb[g] + 1];
    end
  endgenerate

  assign sel32 = sel_code_t'(pb_reg[1:0]);
  assign sel33 = sel_code_t'(pb_reg[3:2]);
  assign sel34 = sel_code_t'(pb_reg[5:4]);

  // reserved codes fall back to general I/O, so such a pad follows gpio_out and gpio_oe
  always_comb
  begin
    drv.out = gpio_out;
    drv.oe = gpio_oe;
    unique case (sel32)
      SEL_ALT1:
      begin
        drv.out[0] = 1'b0;
        drv.oe[0] = i2c_port_data_line_oe;
      end
      SEL_ALT2:
      begin
        drv.out[0] = 1'b0;
        drv.oe[0] = 1'b0;
      end
      SEL_ALT3:
      begin
        drv.out[0] = conversion_start_a_out;
        drv.oe[0] = 1'b1;
      end
      SEL_GPIO: ;
    endcase
    unique case (sel33)
      SEL_ALT1:
      begin
        drv.out[1] = 1'b0;
        drv.oe[1] = i2c_port_clock_line_oe;
      end
      SEL_ALT2:
      begin
        drv.out[1] = pwm_sync_pulse_out;
        drv.oe[1] = 1'b1;
      end
      SEL_ALT3:
      begin
        drv.out[1] = conversion_start_b_out;
        drv.oe[1] = 1'b1;
      end
      SEL_GPIO: ;
    endcase
    if (sel34 == SEL_ALT1)
    begin
      drv.out[2] = comparator2_output;
      drv.oe[2] = 1'b1;
    end
    // pins 35..38 have only general I/O codes; jtag overrides them
    if (jtag_reset)
    begin
      drv.oe[3] = 1'b0;
      drv.oe[4] = 1'b0;
      drv.out[5] = jtag_tdo;
      drv.oe[5] = 1'b1;
      drv.oe[6] = 1'b0;
    end
  end

  assign pad_out = drv.out;
  assign pad_oe = drv.oe;
  assign gpio_in = pad_in;
  assign i2c_port_data_line = (sel32 == SEL_ALT1) ? pad_in[0] : 1'b1;
  assign i2c_port_clock_line = (sel33 == SEL_ALT1) ? pad_in[1] : 1'b1;
  assign pwm_sync_pulse_in = (sel32 == SEL_ALT2) ? pad_in[0] : 1'b0;
  assign jtag_tdi = jtag_reset ? pad_in[3] : 1'b0;
  assign jtag_tms = jtag_reset ? pad_in[4] : 1'b1;
  assign jtag_tck = jtag_reset ? pad_in[6] : 1'b0;
  assign external_oscillator_clock_in = pad_in[6];

  // read checks built from a setup cycle and the access cycle after it; analog writes from the access cycle alone
  sequence pb_rd_setup_seq;
    psel && !penable && !pwrite && paddr == `PB_SEL_ADDR;
  endsequence
  sequence an_rd_setup_seq;
    psel && !penable && !pwrite && paddr == `AN_SEL_ADDR;
  endsequence
  sequence bad_rd_setup_seq;
    psel && !penable && !pwrite && !rd.paddr_ok;
  endsequence
  sequence access_seq;
    psel && penable && pready;
  endsequence
  sequence an_wr_seq;
    psel && penable && pwrite && paddr == `AN_SEL_ADDR;
  endsequence

  // register contents
  AST_PB_RESERVED_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    pb_reg[31:14] == 18'h0_0000)
    else $error("reserved port b bits set");
  AST_AN_RESERVED_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    (an_reg & ~`AN_SEL_MASK) == 32'h0000_0000)
    else $error("reserved analog bits set");
  AST_PB_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    wr_acc && paddr == `PB_SEL_ADDR |=> pb_reg[13:0] == $past(pwdata[13:0]))
    else $error("port b write lost");
  AST_PB_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !(wr_acc && paddr == `PB_SEL_ADDR) |=> $stable(pb_reg))
    else $error("port b changed without write");
  AST_AN_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !(wr_acc && paddr == `AN_SEL_ADDR) |=> $stable(an_reg))
    else $error("analog changed without write");
  AST_PB_READ: assert property (@(posedge clk) disable iff (sys_rst)
    pb_rd_setup_seq ##1 access_seq |-> prdata == $past(pb_reg))
    else $error("port b read wrong");
  AST_AN_READ: assert property (@(posedge clk) disable iff (sys_rst)
    an_rd_setup_seq ##1 access_seq |-> prdata == $past(an_reg))
    else $error("analog read wrong");
  AST_BAD_READ: assert property (@(posedge clk) disable iff (sys_rst)
    bad_rd_setup_seq ##1 access_seq |-> prdata == 32'h0000_0000 && pslverr)
    else $error("unmapped read wrong");

  // analog digital enables
  AST_AN_EN: assert property (@(posedge clk) disable iff (sys_rst)
    wr_acc && paddr == `AN_SEL_ADDR && pwdata[29] |=> !analog_digital_en[5])
    else $error("analog enable wrong");
  AST_AN_EN_ALL: assert property (@(posedge clk) disable iff (sys_rst)
    an_wr_seq |=> analog_digital_en == ~{$past(pwdata[29]), $past(pwdata[25]),
    $past(pwdata[21]), $past(pwdata[13]), $past(pwdata[9]), $past(pwdata[5])})
    else $error("analog enables wrong");

  // jtag takes pins 35 to 38 only while its reset input is high
  AST_TCK_PATH: assert property (@(posedge clk) disable iff (sys_rst)
    jtag_reset |-> jtag_tck == pad_in[6] && !pad_oe[6])
    else $error("tck path wrong");
  AST_JTAG_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
    !jtag_reset |-> !jtag_tck && jtag_tms && !jtag_tdi)
    else $error("jtag idle levels wrong");
  AST_PIN38_GPIO: assert property (@(posedge clk) disable iff (sys_rst)
    !jtag_reset |-> pad_oe[6] == gpio_oe[6] && pad_out[6] == gpio_out[6])
    else $error("pin 38 general path wrong");
  AST_OSC: assert property (@(posedge clk) disable iff (sys_rst)
    external_oscillator_clock_in == pad_in[6])
    else $error("osc path wrong");
  AST_TDO_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
    jtag_reset |-> pad_oe[5] && pad_out[5] == jtag_tdo)
    else $error("tdo drive wrong");
  AST_TMS_PATH: assert property (@(posedge clk) disable iff (sys_rst)
    jtag_reset |-> jtag_tms == pad_in[4] && !pad_oe[4])
    else $error("tms path wrong");
  AST_TDI_PATH: assert property (@(posedge clk) disable iff (sys_rst)
    jtag_reset |-> jtag_tdi == pad_in[3] && !pad_oe[3])
    else $error("tdi path wrong");

  // peripheral routes of pins 32 to 34
  AST_CMP2: assert property (@(posedge clk) disable iff (sys_rst)
    pb_reg[5:4] == 2'h1 |-> pad_oe[2] && pad_out[2] == comparator2_output)
    else $error("comparator route wrong");
  AST_I2C_CLOCK: assert property (@(posedge clk) disable iff (sys_rst)
    pb_reg[3:2] == 2'h1 |-> pad_oe[1] == i2c_port_clock_line_oe && !pad_out[1] &&
    i2c_port_clock_line == pad_in[1])
    else $error("i2c clock route wrong");
  AST_SYNC_OUT: assert property (@(posedge clk) disable iff (sys_rst)
    pb_reg[3:2] == 2'h2 |-> pad_oe[1] && pad_out[1] == pwm_sync_pulse_out)
    else $error("sync out route wrong");
  AST_SOCB: assert property (@(posedge clk) disable iff (sys_rst)
    pb_reg[3:2] == 2'h3 |-> pad_out[1] == conversion_start_b_out)
    else $error("start b route wrong");
  AST_I2C_DATA: assert property (@(posedge clk) disable iff (sys_rst)
    pb_reg[1:0] == 2'h1 |-> pad_oe[0] == i2c_port_data_line_oe && !pad_out[0] &&
    i2c_port_data_line == pad_in[0])
    else $error("i2c data route wrong");
  AST_SYNC_IN: assert property (@(posedge clk) disable iff (sys_rst)
    pb_reg[1:0] == 2'h2 |-> !pad_oe[0] && pwm_sync_pulse_in == pad_in[0])
    else $error("sync in route wrong");
  AST_SOCA: assert property (@(posedge clk) disable iff (sys_rst)
    pb_reg[1:0] == 2'h3 |-> pad_out[0] == conversion_start_a_out)
    else $error("start a route wrong");

endmodule
